// ==== bench/fbpwm_led_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fbpwm_led_model
  import fbpwm_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic win, // Measuring window, high while counting.
  input wire logic [NLED-1:0] led, // LED drives from the modulator.
  output int on_cnt [NLED] // Lit cycles per LED within the window.
);
  ////////////////////////////////////////////////////////////////////////////
  // Each LED integrates its lit time, which is what the eye sees as brightness.
  always @(negedge pclk)
  begin
    for (int i = 0; i < NLED; i++)
    begin
      if (!win)
        on_cnt[i] <= 0;
      else if (led[i] === 1'b1)
        on_cnt[i] <= on_cnt[i] + 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_fbpwm_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_fbpwm_top;
  import fbpwm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, touch_det = 0, win = 0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, q;
  logic pready, pslverr, err, pwm_out, gpio_led;
  logic [NLED-1:0] led_out;
  int mismatches = 0, n_checks = 0, on_cnt [NLED];
  int seed_v, n1, n2, per, lvl, t;

  always #12.5 pclk = ~pclk;

  fbpwm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touch_det(touch_det), .pwm_out(pwm_out), .led_out(led_out),
    .gpio_led(gpio_led));
  fbpwm_led_model i_leds (.pclk(pclk), .win(win), .led(led_out), .on_cnt(on_cnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic int lut(input int l);
    return $rtoi(LUT_MAX * ($exp(l * LUT_B) - 1.0) / ($exp(LUT_MAX * LUT_B) - 1.0) + 0.5);
  endfunction

  // Any window of whole output cycles holds the same lit time, so no phase sync is needed.
  task automatic run(input int a, b, p, l, map, input logic [3:0] mask);
    int tp, duty, hi, highs, rises;
    logic prev;
    tp = a * b * (p + 1);
    duty = map ? lut(l) : l;
    hi = a * b * ((duty > p + 1) ? p + 1 : duty);
    highs = 0;
    rises = 0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_DIV, DW'(b * 256 + a));
    apb(1'b1, ADDR_PERIOD, DW'(p));
    apb(1'b1, ADDR_LEVEL, DW'(l));
    apb(1'b1, ADDR_CTRL, {24'h0, mask, 2'b00, map[0], 1'b1});
    repeat (2 * tp + 8) @(posedge pclk);
    win <= 1'b1;
    prev = pwm_out;
    repeat (2 * tp) @(negedge pclk)
    begin
      highs += int'(pwm_out);
      rises += int'(pwm_out && !prev);
      prev = pwm_out;
    end
    // The model counts on the falling edge; its last count settles before this edge.
    @(posedge pclk);
    win <= 1'b0;
    chk("pwm_high", DW'(2 * hi), DW'(highs));
    chk("pwm_rises", (duty > 0 && duty <= p) ? 32'h2 : 32'h0, DW'(rises));
    for (int i = 0; i < NLED; i++)
      chk("led_high", mask[i] ? DW'(2 * hi) : 32'h0, DW'(on_cnt[i]));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_duty", DW'(duty), {24'h0, q[23:16]});
    chk("status_period", DW'(p), {24'h0, q[31:24]});
    chk("status_cnt_in_period", 32'h1, {31'h0, (q[7:0] <= p[7:0])});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // The scenarios need about 45000 cycles, most of them in the buzzer case.
    repeat (60000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    seed_v = $urandom(9);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", {24'h0, CTRL_RST}, q);
    chk("ctrl_err", 32'h0, {31'h0, err});
    apb(1'b0, ADDR_DIV, 32'h0);
    chk("div_rst", {16'h0, DIV_RST, DIV_RST}, q);
    apb(1'b0, ADDR_PERIOD, 32'h0);
    chk("period_rst", {24'h0, PERIOD_RST}, q);
    apb(1'b0, ADDR_LEVEL, 32'h0);
    chk("level_rst", {24'h0, LEVEL_RST}, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_ro", {PERIOD_RST, 24'h0}, q);
    run(4, 10, 249, 125, 0, 4'hF);
    // Fade up then breathe down while running; each step lands at a wrap.
    run(1, 1, 3, 0, 0, 4'h1);
    for (int v = 1; v < 9; v++)
    begin
      apb(1'b1, ADDR_LEVEL, DW'((v < 5) ? v : 8 - v));
      repeat (10) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("fade_duty", DW'((v < 5) ? v : 8 - v), {24'h0, q[23:16]});
    end
    for (int k = 0; k < 5; k++)
    begin
      n1 = 1 + $urandom % 3;
      n2 = 1 + $urandom % 3;
      per = 2 + $urandom % 8;
      lvl = (k == 0) ? 0 : (k == 1) ? per + 1 : $urandom % (per + 3);
      run(n1, n2, per, lvl, 0, 4'($urandom));
    end
    run(1, 1, 255, 255, 1, 4'hA);
    run(1, 1, 255, 30 + $urandom % 200, 1, 4'($urandom));
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, ADDR_CTRL, {29'h0, s[0], 2'b00});
      repeat (6)
      begin
        t = $urandom % 2;
        @(posedge pclk);
        touch_det <= t[0];
        @(posedge pclk);
        @(negedge pclk);
        chk("gpio_led", {31'h0, t[0] ^ s[0]}, {31'h0, gpio_led});
      end
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== rtl/fbpwm_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module fbpwm_divider
  import fbpwm_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic en, // Input tick to divide.
  input wire logic [7:0] ratio, // Divide ratio; zero acts as one.
  output logic tick // One-cycle pulse every ratio input ticks.
);

  fbpwm_div_st_t s_r;
  fbpwm_div_st_t s_nxt;
  logic [7:0] last;

  always_comb
  begin
    s_nxt = s_r;
    last = (ratio == 8'h00) ? 8'h00 : ratio - ONE8;
    s_nxt.tick = 1'b0;
    if (en)
    begin
      if (s_r.cnt >= last)
      begin
        s_nxt.cnt = 8'h00;
        s_nxt.tick = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + ONE8;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DIV_NO_SPONTANEOUS: assert property (!en |=> !tick)
    else $error("Divider ticked without an input tick.");

endmodule
`default_nettype wire

// ==== rtl/fbpwm_pkg.sv ====
// Function
// - Output rate is clock over N1*N2*(period+1).
// - One cycle spans period plus one ticks.
// - Worked case: 24 MHz, divider product 10000.
// - Larger duty value gives brighter LED.
// - Exponential map from linear level to duty.
// - One modulator output drives several LEDs.
// - Plain output follows touch, sourcing or sinking.
package fbpwm_pkg;

  localparam int NLED = 4;
  localparam int AW = 8;
  localparam int DW = 32;

  // Register byte addresses.
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_DIV = 8'h04;
  localparam logic [AW-1:0] ADDR_PERIOD = 8'h08;
  localparam logic [AW-1:0] ADDR_LEVEL = 8'h0C;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h10;

  // Control register fields.
  localparam int CTRL_EN = 0;
  localparam int CTRL_MAP = 1;
  localparam int CTRL_SINK = 2;
  localparam int CTRL_MASK_LSB = 4;

  // Divider register fields.
  localparam int DIV1_LSB = 0;
  localparam int DIV2_LSB = 8;

  // Status register fields.
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PWM = 8;
  localparam int STAT_DUTY_LSB = 16;
  localparam int STAT_PER_LSB = 24;

  localparam logic [7:0] CTRL_RST = 8'hF0;
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;

  // Brightness curve shape and full scale.
  localparam real LUT_B = 0.02;
  localparam real LUT_MAX = 255.0;
  localparam int LUT_N = 256;

  // Clock figures and the worked buzzer configuration.
  localparam real PCLK_PERIOD_NS = 25.0;
  localparam int WORKED_SYSTEM_CLOCK_HZ = 24000000;
  localparam int WORKED_DIV_PRODUCT = 10000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } fbpwm_apb_req_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } fbpwm_div_st_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] div1;
    logic [7:0] div2;
    logic [7:0] period;
    logic [7:0] level;
    logic [7:0] per_act;
    logic [7:0] duty_act;
    logic [7:0] cnt;
    logic pwm;
    logic [NLED-1:0] led;
    logic gpio;
    logic [DW-1:0] prdata;
  } fbpwm_st_t;

endpackage

// ==== rtl/fbpwm_top.sv ====
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fbpwm_top
  import fbpwm_pkg::*;
(
  input wire logic pclk, // System clock, 40 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write when high.
  input wire logic [AW-1:0] paddr, // APB byte address.
  input wire logic [DW-1:0] pwdata, // APB write data.
  output logic [DW-1:0] prdata, // APB read data, from a flop.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error for an unmapped address.
  input wire logic touch_det, // Touch flag from the scan logic, same clock.
  output logic pwm_out, // Modulator output.
  output logic [NLED-1:0] led_out, // Modulated LED drives.
  output logic gpio_led // Plain on/off LED drive.
);

  fbpwm_apb_req_t req;
  fbpwm_st_t s_r;
  fbpwm_st_t s_nxt;
  logic tick1;
  logic tick2;
  logic hit;
  logic wr;
  logic [7:0] lut [LUT_N];
  logic [7:0] duty_src;
  logic wrap;
  logic pwm_d;
  logic [7:0] ctrl_d;
  logic [NLED-1:0] led_nxt;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  //////////////////////////////////////////////////////////////////////////////
  // Exponential brightness table, built at elaboration so no file is read.

  for (genvar i = 0; i < LUT_N; i++)
  begin : g_lut
    localparam int V = $rtoi(LUT_MAX * ($exp(i * LUT_B) - 1.0)
                             / ($exp(LUT_MAX * LUT_B) - 1.0) + 0.5);
    assign lut[i] = 8'(V);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two divider stages in a chain.

  fbpwm_divider u_div1 (
    .pclk(pclk),
    .presetn(presetn),
    .en(s_r.ctrl[CTRL_EN]),
    .ratio(s_r.div1),
    .tick(tick1)
  );

  fbpwm_divider u_div2 (
    .pclk(pclk),
    .presetn(presetn),
    .en(tick1),
    .ratio(s_r.div2),
    .tick(tick2)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register access and modulator.

  always_comb
  begin
    hit = 1'b0;
    if (req.paddr == ADDR_CTRL)
      hit = 1'b1;
    else if (req.paddr == ADDR_DIV)
      hit = 1'b1;
    else if (req.paddr == ADDR_PERIOD)
      hit = 1'b1;
    else if (req.paddr == ADDR_LEVEL)
      hit = 1'b1;
    else if (req.paddr == ADDR_STATUS)
      hit = 1'b1;
  end

  assign wr = req.psel && req.penable && req.pwrite;
  // Mapping is optional so software can also program raw duty values directly.
  assign duty_src = s_r.ctrl[CTRL_MAP] ? lut[s_r.level] : s_r.level;
  assign wrap = tick2 && (s_r.cnt == s_r.per_act);

  always_comb
  begin
    s_nxt = s_r;
    if (wr)
    begin
      if (req.paddr == ADDR_CTRL)
        s_nxt.ctrl = req.pwdata[7:0];
      else if (req.paddr == ADDR_DIV)
      begin
        s_nxt.div1 = req.pwdata[DIV1_LSB +: 8];
        s_nxt.div2 = req.pwdata[DIV2_LSB +: 8];
      end
      else if (req.paddr == ADDR_PERIOD)
        s_nxt.period = req.pwdata[7:0];
      else if (req.paddr == ADDR_LEVEL)
        s_nxt.level = req.pwdata[7:0];
    end
    // Read data is captured in the setup phase, so it is stable for the access phase.
    if (req.psel && !req.penable && !req.pwrite)
    begin
      s_nxt.prdata = '0;
      if (req.paddr == ADDR_CTRL)
        s_nxt.prdata[7:0] = s_r.ctrl;
      else if (req.paddr == ADDR_DIV)
      begin
        s_nxt.prdata[DIV1_LSB +: 8] = s_r.div1;
        s_nxt.prdata[DIV2_LSB +: 8] = s_r.div2;
      end
      else if (req.paddr == ADDR_PERIOD)
        s_nxt.prdata[7:0] = s_r.period;
      else if (req.paddr == ADDR_LEVEL)
        s_nxt.prdata[7:0] = s_r.level;
      else if (req.paddr == ADDR_STATUS)
      begin
        s_nxt.prdata[STAT_CNT_LSB +: 8] = s_r.cnt;
        s_nxt.prdata[STAT_PWM] = s_r.pwm;
        s_nxt.prdata[STAT_DUTY_LSB +: 8] = s_r.duty_act;
        s_nxt.prdata[STAT_PER_LSB +: 8] = s_r.per_act;
      end
    end
    // While enabled, period and duty are taken only at the wrap so each step of a fade or a
    // breath lands on a whole cycle and never cuts a pulse short.
    if (!s_r.ctrl[CTRL_EN])
    begin
      s_nxt.cnt = 8'h00;
      s_nxt.per_act = s_r.period;
      s_nxt.duty_act = duty_src;
    end
    else if (wrap)
    begin
      s_nxt.cnt = 8'h00;
      s_nxt.per_act = s_r.period;
      s_nxt.duty_act = duty_src;
    end
    else if (tick2)
    begin
      s_nxt.cnt = s_r.cnt + ONE8;
    end
    s_nxt.pwm = pwm_d;
    s_nxt.led = led_nxt;
    s_nxt.gpio = touch_det ^ s_r.ctrl[CTRL_SINK];
  end

  // The LED drives are built from what feeds the state register, not from the
  // next state itself, so they form no loop through it and have one driver.
  assign pwm_d = s_r.ctrl[CTRL_EN] && (s_r.cnt < s_r.duty_act);
  assign ctrl_d = (wr && (req.paddr == ADDR_CTRL)) ? req.pwdata[7:0] : s_r.ctrl;

  for (genvar j = 0; j < NLED; j++)
  begin : g_led
    assign led_nxt[j] = pwm_d && ctrl_d[CTRL_MASK_LSB + j];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.div1 <= DIV_RST;
      s_r.div2 <= DIV_RST;
      s_r.period <= PERIOD_RST;
      s_r.level <= LEVEL_RST;
      s_r.per_act <= PERIOD_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !hit;
  assign pwm_out = s_r.pwm;
  assign led_out = s_r.led;
  assign gpio_led = s_r.gpio;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_setup_div;
    psel && !penable && !pwrite && (paddr == ADDR_DIV);
  endsequence

  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence

  AST_PWM_COMPARE: assert property (
    s_r.ctrl[CTRL_EN] |=> (pwm_out == ($past(s_r.cnt) < $past(s_r.duty_act))))
    else $error("Output does not follow count below compare.");

  AST_CNT_WRAP: assert property (wrap && s_r.ctrl[CTRL_EN] |=> s_r.cnt == 8'h00)
    else $error("Counter did not restart after the period value.");

  AST_CNT_STEP: assert property (
    tick2 && !wrap && s_r.ctrl[CTRL_EN] |=> s_r.cnt == $past(s_r.cnt) + ONE8)
    else $error("Counter did not step on a divided tick.");

  AST_CNT_HOLD: assert property (!tick2 && s_r.ctrl[CTRL_EN] |=> $stable(s_r.cnt))
    else $error("Counter moved without a divided tick.");

  AST_DUTY_LOAD: assert property (wrap && s_r.ctrl[CTRL_EN] |=> s_r.duty_act == $past(duty_src))
    else $error("Duty not loaded from the brightness map at wrap.");

  AST_DISABLED_LOW: assert property (!s_r.ctrl[CTRL_EN] ##1 !s_r.ctrl[CTRL_EN] |=> !pwm_out)
    else $error("Output active while the modulator is off.");

  AST_LED_FANOUT: assert property (led_out == ({NLED{pwm_out}} & s_r.ctrl[CTRL_MASK_LSB +: NLED]))
    else $error("LED drives differ from the masked modulator output.");

  AST_GPIO_TOUCH: assert property (##1 gpio_led == ($past(touch_det) ^ $past(s_r.ctrl[CTRL_SINK])))
    else $error("Plain LED drive does not follow touch and polarity.");

  AST_RD_DIV: assert property (s_rd_setup_div ##1 s_rd_access |->
    prdata[DIV1_LSB +: 8] == s_r.div1 && prdata[DIV2_LSB +: 8] == s_r.div2)
    else $error("Divider read returned wrong data.");

endmodule
`default_nettype wire
